/* File: src/sov_map.svh */
/*
 Register map, field positions, reset values and timing constants of the
 service override block. Assumes a 100 MHz pclk.
*/
`ifndef SOV_MAP_SVH
`define SOV_MAP_SVH
`define SOV_NOUT 8
`define SOV_NGRP 2
`define SOV_NPROBE 4
`define SOV_NAO 2
`define SOV_TB_US 1000
`define SOV_CLK_MHZ 100
`define SOV_TB_CYC (`SOV_TB_US * `SOV_CLK_MHZ)
`define SOV_A_CTRL 12'h000
`define SOV_A_OUTCMD 12'h004
`define SOV_A_GRPCMD 12'h008
`define SOV_A_DISCMD 12'h00c
`define SOV_A_TOUT 12'h010
`define SOV_A_STATUS 12'h014
`define SOV_A_OUTSTAT 12'h018
`define SOV_A_PROBECMD 12'h01c
`define SOV_A_PROBEVAL 12'h020
`define SOV_A_AOCMD 12'h024
`define SOV_A_AOVAL 12'h028
`define SOV_A_VIEW 12'h030
`define SOV_B_REBOOT 0
`define SOV_B_DISARM_EN 1
`define SOV_B_PROBE_MODE 2
`define SOV_B_AO_MODE 3
`define SOV_CTRL_RST 32'h0000_0000
`define SOV_TOUT_RST 16'h000a
`define SOV_PROTECTED_MASK 8'hc0
`endif

/* File: src/sov_pkg.sv */
/*
 Types of the service override block.
 Assumes sov_map.svh constants.
*/
`default_nettype none
package sov_pkg;
	typedef enum logic [1:0] {SOV_IDLE, SOV_PERM, SOV_TIMED} sov_mode_e;
	typedef struct packed {
		logic [1:0] mode;
		logic val;
		logic [15:0] cnt;
	} sov_ovr_s;
endpackage : sov_pkg
`default_nettype wire

/* File: src/sov_top.sv */
/*
 Service override block: output forcing, group disarm, probe and analog
 output forcing, reboot, healthy indicator and phase sequence mismatch.
 Assumes an APB master on pclk; field inputs are asynchronous pins.
*/
// Implementation choices: the register addresses and the APB register port.
`include "sov_map.svh"
`default_nettype none
// Function
// - Output override is permanent or timed
// - Timed override expiry releases the output
// - Permanent override holds until removed
// - Single output and whole group scopes
// - Group override wins over single override
// - Override ignored while output disarmed
// - Override needs direct command and armed output
// - Disarm per group suppresses contact switching
// - Zone interlock and supervision never disarmed
// - Timed disarm ends at timer expiry
// - Permanent disarm holds until re-armed
// - No disarm while output latched
// - No disarm while hold timer runs
// - Disarm needs control setting and command
// - Probe readings forced permanent or timed
// - Probe view live, frozen in mode
// - Probe view live again after mode
// - Analog outputs forced permanent or timed
// - Analog view shows assigned value first
// - Reboot request restarts the device
// - Steady green only when booted and running
// - Flag phase rotation differing from setting
module sov_top
	import sov_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`SOV_NOUT-1:0] prot_out,
	input wire logic [`SOV_NOUT-1:0] out_latched,
	input wire logic [`SOV_NOUT-1:0] out_hold_run,
	input wire logic [31:0] probe_meas,
	input wire logic [15:0] ao_assigned,
	input wire logic boot_done,
	input wire logic prot_running,
	input wire logic phase_calc,
	input wire logic phase_set,
	output logic [`SOV_NOUT-1:0] contact_out,
	output logic [31:0] probe_out,
	output logic [15:0] ao_out,
	output logic healthy_green,
	output logic phase_mismatch,
	output logic reboot_req
);
	localparam int NO = `SOV_NOUT;
	localparam int GW = NO / `SOV_NGRP;
	localparam logic [16:0] TB_CYC = 17'(`SOV_TB_CYC);
	localparam logic [NO-1:0] PROT_MASK = `SOV_PROTECTED_MASK;

	function automatic logic [15:0] tdec(input logic [1:0] m, input logic [15:0] c, input logic t);
		tdec = (m == 2'(SOV_TIMED) && t && c != 16'h0000) ? c - 16'h0001 : c;
	endfunction : tdec

	function automatic logic [1:0] texp(input logic [1:0] m, input logic [15:0] c, input logic t);
		texp = (m == 2'(SOV_TIMED) && t && c == 16'h0001) ? 2'(SOV_IDLE) : m;
	endfunction : texp

	logic [NO-1:0] lat_s1, lat_s2, hold_s1, hold_s2, prot_s1, prot_s2;
	logic [31:0] pm_s1, pm_s2;
	logic [15:0] ao_s1, ao_s2;
	logic [3:0] misc_s1, misc_s2;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lat_s1 <= '0; lat_s2 <= '0; hold_s1 <= '0; hold_s2 <= '0;
			prot_s1 <= '0; prot_s2 <= '0; pm_s1 <= '0; pm_s2 <= '0;
			ao_s1 <= '0; ao_s2 <= '0; misc_s1 <= '0; misc_s2 <= '0;
		end
		else
		begin
			lat_s1 <= out_latched; lat_s2 <= lat_s1;
			hold_s1 <= out_hold_run; hold_s2 <= hold_s1;
			prot_s1 <= prot_out; prot_s2 <= prot_s1;
			pm_s1 <= probe_meas; pm_s2 <= pm_s1;
			ao_s1 <= ao_assigned; ao_s2 <= ao_s1;
			misc_s1 <= {boot_done, prot_running, phase_calc, phase_set};
			misc_s2 <= misc_s1;
		end
	end

	// Time base tick
	logic [16:0] tb_cnt_reg;
	logic tick_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tb_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			tick_reg <= (tb_cnt_reg == TB_CYC - 17'd1);
			tb_cnt_reg <= (tb_cnt_reg == TB_CYC - 17'd1) ? 17'd0 : tb_cnt_reg + 17'd1;
		end
	end

	logic wr, rd_phase;
	assign wr = psel && penable && pwrite;
	assign rd_phase = psel && !penable;

	logic [31:0] ctrl_reg;
	logic [15:0] tout_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= `SOV_CTRL_RST;
			tout_reg <= `SOV_TOUT_RST;
		end
		else if (wr && paddr == `SOV_A_CTRL)
			ctrl_reg <= pwdata;
		else if (wr && paddr == `SOV_A_TOUT)
			tout_reg <= pwdata[15:0];
	end

	// Command words: [1:0] mode, [2] value, [10:8] index
	logic [1:0] cmode;
	logic cval;
	logic [2:0] cidx;
	assign cmode = pwdata[1:0];
	assign cval = pwdata[2];
	assign cidx = pwdata[10:8];

	sov_ovr_s ovr_reg [NO];
	sov_ovr_s grp_reg [`SOV_NGRP];
	sov_ovr_s dis_reg [`SOV_NGRP];
	logic [NO-1:0] disarmed;

	always_comb
	begin
		for (int i = 0; i < NO; i++)
			disarmed[i] = dis_reg[i / GW].mode != 2'(SOV_IDLE) && !PROT_MASK[i];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NO; i++)
				ovr_reg[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < NO; i++)
			begin
				ovr_reg[i].mode <= texp(ovr_reg[i].mode, ovr_reg[i].cnt, tick_reg);
				ovr_reg[i].cnt <= tdec(ovr_reg[i].mode, ovr_reg[i].cnt, tick_reg);
				if (wr && paddr == `SOV_A_OUTCMD && cidx == 3'(i) && !disarmed[i])
				begin
					ovr_reg[i].mode <= cmode;
					ovr_reg[i].val <= cval;
					ovr_reg[i].cnt <= tout_reg;
				end
				if (disarmed[i])
					ovr_reg[i].mode <= 2'(SOV_IDLE);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int g = 0; g < `SOV_NGRP; g++)
			begin
				grp_reg[g] <= '0;
				dis_reg[g] <= '0;
			end
		end
		else
		begin
			for (int g = 0; g < `SOV_NGRP; g++)
			begin
				grp_reg[g].mode <= texp(grp_reg[g].mode, grp_reg[g].cnt, tick_reg);
				grp_reg[g].cnt <= tdec(grp_reg[g].mode, grp_reg[g].cnt, tick_reg);
				dis_reg[g].mode <= texp(dis_reg[g].mode, dis_reg[g].cnt, tick_reg);
				dis_reg[g].cnt <= tdec(dis_reg[g].mode, dis_reg[g].cnt, tick_reg);
				if (wr && paddr == `SOV_A_GRPCMD && cidx == 3'(g))
				begin
					grp_reg[g].mode <= cmode;
					grp_reg[g].val <= cval;
					grp_reg[g].cnt <= tout_reg;
				end
				if (wr && paddr == `SOV_A_DISCMD && cidx == 3'(g))
				begin
					if (cmode == 2'(SOV_IDLE))
						dis_reg[g].mode <= 2'(SOV_IDLE);
					else if (ctrl_reg[`SOV_B_DISARM_EN]
						&& lat_s2[g*GW +: GW] == '0
						&& hold_s2[g*GW +: GW] == '0)
					begin
						dis_reg[g].mode <= cmode;
						dis_reg[g].cnt <= tout_reg;
					end
				end
			end
		end
	end

	// Contact drive, group force before single force
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			contact_out <= '0;
		else
		begin
			for (int i = 0; i < NO; i++)
			begin
				if (disarmed[i])
					contact_out[i] <= 1'b0;
				else if (grp_reg[i / GW].mode != 2'(SOV_IDLE))
					contact_out[i] <= grp_reg[i / GW].val;
				else if (ovr_reg[i].mode != 2'(SOV_IDLE))
					contact_out[i] <= ovr_reg[i].val;
				else
					contact_out[i] <= prot_s2[i];
			end
		end
	end

	// Probe and analog forcing; value word [7:0] value, [17:16] mode, [21:20] channel
	sov_ovr_s pf_reg [`SOV_NPROBE];
	logic [7:0] pval_reg [`SOV_NPROBE];
	sov_ovr_s af_reg [`SOV_NAO];
	logic [7:0] aval_reg [`SOV_NAO];
	logic [31:0] pview_reg;
	logic [15:0] aview_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int k = 0; k < `SOV_NPROBE; k++)
			begin
				pf_reg[k] <= '0;
				pval_reg[k] <= '0;
			end
			for (int k = 0; k < `SOV_NAO; k++)
			begin
				af_reg[k] <= '0;
				aval_reg[k] <= '0;
			end
		end
		else
		begin
			for (int k = 0; k < `SOV_NPROBE; k++)
			begin
				pf_reg[k].mode <= texp(pf_reg[k].mode, pf_reg[k].cnt, tick_reg);
				pf_reg[k].cnt <= tdec(pf_reg[k].mode, pf_reg[k].cnt, tick_reg);
				if (!ctrl_reg[`SOV_B_PROBE_MODE])
					pf_reg[k].mode <= 2'(SOV_IDLE);
				else if (wr && paddr == `SOV_A_PROBECMD && pwdata[21:20] == 2'(k))
				begin
					pf_reg[k].mode <= pwdata[17:16];
					pf_reg[k].cnt <= tout_reg;
					pval_reg[k] <= pwdata[7:0];
				end
			end
			for (int k = 0; k < `SOV_NAO; k++)
			begin
				af_reg[k].mode <= texp(af_reg[k].mode, af_reg[k].cnt, tick_reg);
				af_reg[k].cnt <= tdec(af_reg[k].mode, af_reg[k].cnt, tick_reg);
				if (!ctrl_reg[`SOV_B_AO_MODE])
					af_reg[k].mode <= 2'(SOV_IDLE);
				else if (wr && paddr == `SOV_A_AOCMD && pwdata[21:20] == 2'(k))
				begin
					af_reg[k].mode <= pwdata[17:16];
					af_reg[k].cnt <= tout_reg;
					aval_reg[k] <= pwdata[7:0];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			probe_out <= '0;
			ao_out <= '0;
		end
		else
		begin
			for (int k = 0; k < `SOV_NPROBE; k++)
				probe_out[k*8 +: 8] <= (pf_reg[k].mode != 2'(SOV_IDLE)) ? pval_reg[k]
					: pm_s2[k*8 +: 8];
			for (int k = 0; k < `SOV_NAO; k++)
				ao_out[k*8 +: 8] <= (af_reg[k].mode != 2'(SOV_IDLE)) ? aval_reg[k]
					: ao_s2[k*8 +: 8];
		end
	end

	// Service views: live until mode set, then frozen
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pview_reg <= '0;
			aview_reg <= '0;
		end
		else
		begin
			if (!ctrl_reg[`SOV_B_PROBE_MODE])
				pview_reg <= pm_s2;
			if (!ctrl_reg[`SOV_B_AO_MODE])
				aview_reg <= ao_s2;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			healthy_green <= 1'b0;
			phase_mismatch <= 1'b0;
			reboot_req <= 1'b0;
		end
		else
		begin
			healthy_green <= misc_s2[3] && misc_s2[2];
			phase_mismatch <= misc_s2[1] != misc_s2[0];
			reboot_req <= wr && paddr == `SOV_A_CTRL && pwdata[`SOV_B_REBOOT];
		end
	end

	logic [NO-1:0] ovr_act;
	always_comb
	begin
		for (int i = 0; i < NO; i++)
			ovr_act[i] = ovr_reg[i].mode != 2'(SOV_IDLE) || grp_reg[i / GW].mode != 2'(SOV_IDLE);
	end

	// APB: one wait-free access, reads answered from a setup-cycle decode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= rd_phase;
			pslverr <= 1'b0;
			if (rd_phase)
			begin
				case (paddr)
					`SOV_A_CTRL: prdata <= {ctrl_reg[31:1], 1'b0};
					`SOV_A_TOUT: prdata <= {16'h0000, tout_reg};
					`SOV_A_STATUS: prdata <= {24'h000000, 5'h00, phase_mismatch,
						healthy_green, tick_reg};
					`SOV_A_OUTSTAT: prdata <= {8'h00, ovr_act, disarmed, contact_out};
					`SOV_A_PROBEVAL: prdata <= probe_out;
					`SOV_A_AOVAL: prdata <= {16'h0000, ao_out};
					`SOV_A_VIEW: prdata <= {aview_reg, pview_reg[15:0]};
					`SOV_A_OUTCMD, `SOV_A_GRPCMD, `SOV_A_DISCMD, `SOV_A_PROBECMD,
					`SOV_A_AOCMD: prdata <= '0;
					default:
					begin
						prdata <= '0;
						pslverr <= 1'b1;
					end
				endcase
			end
			else
				pslverr <= 1'b0;
		end
	end
endmodule : sov_top
`default_nettype wire

/* File: sim/sov_top_props.sv */
/* Port checker of sov_top.
 Assumes a zero-wait APB slave; bound into sov_top below. */
`include "sov_map.svh"
`default_nettype none
module sov_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [`SOV_NOUT-1:0] contact_out,
	input wire logic [15:0] ao_out,
	input wire logic boot_done,
	input wire logic prot_running,
	input wire logic phase_calc,
	input wire logic phase_set,
	input wire logic healthy_green,
	input wire logic phase_mismatch,
	input wire logic reboot_req
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_READY_ZERO_WAIT: assert property (psel && penable |-> pready)
		else $error("pready missing in access phase");
	AST_READY_ONCE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_UNMAPPED: assert property (psel && penable && paddr == 12'h02c |-> pslverr && pready)
		else $error("unmapped access not refused");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_REBOOT_SOON: assert property (psel && penable && pwrite &&
		paddr == `SOV_A_CTRL && pwdata[`SOV_B_REBOOT] |-> ##[0:2] reboot_req)
		else $error("reboot request missing");
	AST_REBOOT_PULSE: assert property (reboot_req |=> !reboot_req)
		else $error("reboot request not a pulse");
	AST_GREEN_ON: assert property ((boot_done && prot_running) [*6] |-> healthy_green)
		else $error("healthy indicator off while running");
	AST_GREEN_OFF: assert property (!(boot_done && prot_running) [*6] |-> !healthy_green)
		else $error("healthy indicator on while not running");
	AST_PHASE_ON: assert property ((phase_calc != phase_set) [*6] |-> phase_mismatch)
		else $error("phase mismatch not flagged");
	AST_PHASE_OFF: assert property ((phase_calc == phase_set) [*6] |-> !phase_mismatch)
		else $error("phase mismatch flagged falsely");
	AST_RESET_CLEAR: assert property ($rose(presetn) |-> contact_out == 8'h00 && ao_out == 16'h0000)
		else $error("outputs not cleared by reset");
endmodule : sov_props
bind sov_top sov_props i_sov_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .contact_out, .ao_out, .boot_done, .prot_running,
	.phase_calc, .phase_set, .healthy_green, .phase_mismatch, .reboot_req);
`default_nettype wire

/* File: sim/sov_field.sv */
/* Contact side model: release hold timer of each output contact.
 Assumes the demand is seen raw, one timer start per falling edge. */
`default_nettype none
module sov_field #(
	parameter int HOLD = 50
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] prot_out,
	output logic [7:0] out_hold_run
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt [8];
	logic [7:0] prev;
	// Hold runs for HOLD cycles after a demand drops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev <= 8'h00;
			cnt <= '{default: 0};
		end
		else
		begin
			prev <= prot_out;
			for (int i = 0; i < 8; i++)
			begin
				if (prev[i] && !prot_out[i])
					cnt[i] <= HOLD;
				else if (cnt[i] > 0)
					cnt[i] <= cnt[i] - 1;
			end
		end
	end
	always_comb
	begin
		for (int i = 0; i < 8; i++)
			out_hold_run[i] = cnt[i] > 0;
	end
endmodule : sov_field
`default_nettype wire

/* File: sim/sov_top_test.sv */
/* Self-checking bench of sov_top.
 Assumes sov_field drives the hold timers; override timers never expire here. */
`include "sov_map.svh"
`default_nettype none
module sov_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, snap = '0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, probe_meas = '0, prdata, probe_out, obs, p, a;
	logic [7:0] prot_out = '0, out_latched = '0, out_hold_run, contact_out;
	logic [15:0] ao_assigned = '0, ao_out;
	logic boot_done = '0, prot_running = '0, phase_calc = '0, phase_set = '0;
	logic pready, pslverr, healthy_green, phase_mismatch, reboot_req;
	logic [1:0] snap_sel = '0;
	logic [32:0] got, e;
	logic [32:0] expq [$];
	int errors = 0, samples_checked = 0, k;
	always #5 pclk = ~pclk;
	sov_top i_sov_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .prot_out, .out_latched, .out_hold_run, .probe_meas, .ao_assigned,
		.boot_done, .prot_running, .phase_calc, .phase_set, .contact_out, .probe_out, .ao_out,
		.healthy_green, .phase_mismatch, .reboot_req);
	sov_field #(.HOLD(50)) i_sov_field (.pclk, .presetn, .prot_out, .out_hold_run);
	assign obs = snap_sel == 2'h0 ? {24'h0, contact_out} : snap_sel == 2'h1 ? probe_out :
		snap_sel == 2'h2 ? {16'h0, ao_out} : {30'h0, phase_mismatch, healthy_green};
	always @(posedge pclk)
	begin
		if (snap || (psel && penable && pready === 1'b1 && !pwrite))
		begin
			got = snap ? {1'b0, obs} : {pslverr, prdata};
			e = expq.pop_front();
			samples_checked++;
			if (got !== e)
			begin
				errors++;
				$display("ERROR at %0t: expected %h, got %h", $time, e, got);
			end
		end
	end
	function automatic logic [31:0] oc(input logic [1:0] m, input logic v, input logic [2:0] i);
		return {21'h0, i, 5'h0, v, m};
	endfunction : oc
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [11:0] ad, input logic [32:0] x);
		expq.push_back(x);
		apb(1'b0, ad, 32'h0);
	endtask : rd
	// Settle through input synchronisers, then sample one output group
	task automatic look(input logic [1:0] s, input logic [31:0] x);
		repeat (6) @(posedge pclk);
		expq.push_back({1'b0, x});
		snap <= 1'b1;
		snap_sel <= s;
		@(posedge pclk);
		snap <= 1'b0;
	endtask : look
	task automatic report_and_stop();
		$display("checked %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#200000;
		errors++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(70772));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`SOV_A_CTRL, 33'h0);
		rd(`SOV_A_TOUT, {17'h0, `SOV_TOUT_RST});
		p = $urandom_range(32'hffff, 32'h1000);
		apb(1'b1, `SOV_A_TOUT, p);
		rd(`SOV_A_TOUT, {1'b0, p});
		rd(12'h02c, {1'b1, 32'h0});
		apb(1'b1, 12'h02c, p);
		$display("registers done");
		k = $urandom_range(6, 0);
		apb(1'b1, `SOV_A_OUTCMD, oc(2'h1, 1'b1, k[2:0]));
		look(2'h0, 32'h1 << k);
		apb(1'b1, `SOV_A_OUTCMD, oc(2'h2, 1'b1, 3'h7));
		look(2'h0, (32'h1 << k) | 32'h80);
		apb(1'b1, `SOV_A_GRPCMD, oc(2'h1, 1'b0, 3'h0));
		apb(1'b1, `SOV_A_GRPCMD, oc(2'h1, 1'b1, 3'h1));
		look(2'h0, 32'hf0);
		apb(1'b1, `SOV_A_GRPCMD, oc(2'h0, 1'b0, 3'h0));
		apb(1'b1, `SOV_A_GRPCMD, oc(2'h0, 1'b0, 3'h1));
		look(2'h0, (32'h1 << k) | 32'h80);
		apb(1'b1, `SOV_A_OUTCMD, oc(2'h0, 1'b0, k[2:0]));
		apb(1'b1, `SOV_A_OUTCMD, oc(2'h0, 1'b0, 3'h7));
		p = $urandom;
		prot_out <= p[7:0];
		look(2'h0, {24'h0, p[7:0]});
		$display("overrides done");
		prot_out <= 8'hff;
		apb(1'b1, `SOV_A_DISCMD, oc(2'h1, 1'b0, 3'h1));
		look(2'h0, 32'hff);
		apb(1'b1, `SOV_A_CTRL, 32'h2);
		out_latched <= 8'h10;
		repeat (5) @(posedge pclk);
		apb(1'b1, `SOV_A_DISCMD, oc(2'h2, 1'b0, 3'h1));
		look(2'h0, 32'hff);
		out_latched <= 8'h00;
		prot_out <= 8'hdf;
		repeat (5) @(posedge pclk);
		apb(1'b1, `SOV_A_DISCMD, oc(2'h2, 1'b0, 3'h1));
		look(2'h0, 32'hdf);
		prot_out <= 8'hff;
		repeat (60) @(posedge pclk);
		apb(1'b1, `SOV_A_DISCMD, oc(2'h2, 1'b0, 3'h1));
		look(2'h0, 32'hcf);
		apb(1'b1, `SOV_A_OUTCMD, oc(2'h1, 1'b1, 3'h4));
		apb(1'b1, `SOV_A_DISCMD, oc(2'h1, 1'b0, 3'h0));
		look(2'h0, 32'hc0);
		apb(1'b1, `SOV_A_DISCMD, oc(2'h0, 1'b0, 3'h0));
		apb(1'b1, `SOV_A_DISCMD, oc(2'h0, 1'b0, 3'h1));
		look(2'h0, 32'hff);
		$display("disarm done");
		p = $urandom;
		a = $urandom;
		probe_meas <= p;
		ao_assigned <= a[15:0];
		look(2'h1, p);
		rd(`SOV_A_VIEW, {1'b0, a[15:0], p[15:0]});
		apb(1'b1, `SOV_A_CTRL, 32'hc);
		probe_meas <= ~p;
		ao_assigned <= ~a[15:0];
		repeat (6) @(posedge pclk);
		rd(`SOV_A_VIEW, {1'b0, a[15:0], p[15:0]});
		apb(1'b1, `SOV_A_PROBECMD, {10'h0, 2'h2, 2'h0, 2'h1, 8'h0, 8'h5a});
		look(2'h1, {~p[31:24], 8'h5a, ~p[15:0]});
		apb(1'b1, `SOV_A_AOCMD, {10'h0, 2'h1, 2'h0, 2'h2, 8'h0, 8'ha5});
		look(2'h2, {16'h0, 8'ha5, ~a[7:0]});
		apb(1'b1, `SOV_A_CTRL, 32'h0);
		look(2'h1, ~p);
		rd(`SOV_A_VIEW, {1'b0, ~a[15:0], ~p[15:0]});
		look(2'h2, {16'h0, ~a[15:0]});
		$display("probe and analog done");
		boot_done <= 1'b1;
		prot_running <= 1'b1;
		phase_calc <= 1'b1;
		look(2'h3, 32'h3);
		prot_running <= 1'b0;
		phase_set <= 1'b1;
		look(2'h3, 32'h0);
		apb(1'b1, `SOV_A_CTRL, 32'h1);
		rd(`SOV_A_CTRL, 33'h0);
		apb(1'b1, `SOV_A_OUTCMD, oc(2'h1, 1'b0, 3'h2));
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		look(2'h0, 32'hff);
		rd(`SOV_A_TOUT, {17'h0, `SOV_TOUT_RST});
		$display("status and reset done");
		report_and_stop();
	end
endmodule : sov_top_test
`default_nettype wire
